// ---- rwps_host.sv ----
// Host bus and oscillator model facing the watchdog supervisor
`timescale 1ns/10ps
`default_nettype none
module rwps_host (
  input  wire logic       clock,
  input  wire logic       data_oe,
  input  wire logic [7:0] data_out,
  output logic            cs_n,
  output logic            ms_n,
  output logic            we_n,
  output logic            oe_n,
  output logic      [3:0] addr,
  output logic      [7:0] wdata,
  output logic            osc
);
  // Oscillator sped up so that the timeouts the test uses fit a short run
  initial begin
    osc = 1'b0;
    forever begin
      repeat (2) @(posedge clock);
      #1 osc = ~osc;
    end
  end
  initial begin
    cs_n  = 1'b1;
    ms_n  = 1'b1;
    we_n  = 1'b1;
    oe_n  = 1'b1;
    addr  = 4'h0;
    wdata = 8'h00;
  end
  // Steering bit forced to zero; held long enough for the pin synchronisers
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    addr  = a;
    wdata = (a == rwps_pkg::REG_WATCHDOG) ? {1'b0, d[6:0]} : d;
    cs_n  = 1'b0;
    we_n  = 1'b0;
    repeat (4) @(posedge clock);
    #1 we_n = 1'b1;
    cs_n = 1'b1;
    repeat (4) @(posedge clock);
    // Released lines show the inverse of the last value
    #1 addr = ~a;
    wdata = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic ok);
    @(posedge clock) #1;
    addr = a;
    cs_n = 1'b0;
    oe_n = 1'b0;
    ok   = 1'b0;
    d    = 8'h00;
    repeat (8) begin
      @(posedge clock) #1;
      if (data_oe === 1'b1 && ok === 1'b0) begin
        ok = 1'b1;
        d  = data_out;
      end
    end
    cs_n = 1'b1;
    oe_n = 1'b1;
    repeat (4) @(posedge clock);
    #1 addr = ~a;
  endtask
endmodule
`default_nettype wire

// ---- rwps_pkg.sv ----
// Package with register map, field layout and timing constants of the watchdog supervisor
package rwps_pkg;
  // Clock register indices on the four low address pins
  localparam logic [3:0] REG_FLAGS    = 4'h0;
  localparam logic [3:0] REG_ALARM    = 4'h6;
  localparam logic [3:0] REG_WATCHDOG = 4'h7;
  // Field positions
  localparam int FLAGS_TIMEOUT_BIT = 7;
  localparam int ALARM_IRQ_EN_BIT  = 7;
  localparam int ALARM_BACKUP_BIT  = 6;
  localparam int WD_STEER_BIT      = 7;
  localparam int WD_MULT_LSB       = 2;
  localparam int WD_MULT_W         = 5;
  localparam int WD_RES_W          = 2;
  // Reset values
  localparam logic [7:0] WATCHDOG_RESET = 8'h00;
  localparam logic [1:0] ALARM_RESET    = 2'h0;
  // Resolution codes
  localparam logic [1:0] RES_SIXTEENTH = 2'h0;
  localparam logic [1:0] RES_QUARTER   = 2'h1;
  localparam logic [1:0] RES_ONE       = 2'h2;
  localparam logic [1:0] RES_FOUR      = 2'h3;
  // Timing
  localparam int CLK_MHZ           = 40;
  localparam int OSC_HZ            = 32768;
  localparam int STEP_BASE_TICKS   = OSC_HZ / 16;
  localparam int RECOVERY_TIME_US  = 2000;
  localparam int RESET_HOLD_TIME_US = 150000;
  localparam int RECOVERY_CYCLES   = RECOVERY_TIME_US * CLK_MHZ;
  localparam int RESET_HOLD_CYCLES = RESET_HOLD_TIME_US * CLK_MHZ;
  localparam int SYNC_W            = 19;
endpackage

// ---- rwps_watchdog.sv ----
// Watchdog timer, power-on defaults and supply supervision of the clock module
`timescale 1ns/10ps
`default_nettype none
module rwps_watchdog #(
  parameter int unsigned RECOVERY_CYCLES   = rwps_pkg::RECOVERY_CYCLES,
  parameter int unsigned RESET_HOLD_CYCLES = rwps_pkg::RESET_HOLD_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       clock_select_n,
  input  wire logic       memory_select_n,
  input  wire logic       write_n,
  input  wire logic       output_n,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] data_in,
  input  wire logic       supply_above_trip,
  input  wire logic       osc_in,
  input  wire logic       oscillator_halt_bit,
  output logic      [7:0] data_out,
  output logic            data_oe,
  output logic            interrupt_output,
  output logic            interrupt_oe,
  output logic            supply_reset_output,
  output logic            supply_reset_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; every pin is asynchronous to clock
  logic [rwps_pkg::SYNC_W-1:0] sync1, sync2;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sync1 <= 19'h78001;
      sync2 <= 19'h78001;
    end else begin
      sync1 <= {clock_select_n, memory_select_n, write_n, output_n, addr, data_in,
                supply_above_trip, osc_in, oscillator_halt_bit};
      sync2 <= sync1;
    end
  end

  logic       cs_n_s, ms_n_s, we_n_s, oe_n_s, ok_s, osc_s, halt_s;
  logic [3:0] addr_s;
  logic [7:0] din_s;

  assign {cs_n_s, ms_n_s, we_n_s, oe_n_s, addr_s, din_s, ok_s, osc_s, halt_s} = sync2;

  ////////////////////////////////////////////////////////////////////////////
  // Supply supervision
  logic [31:0] up_cnt;
  logic        access_ok;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      up_cnt <= 32'h0;
    end else if (!ok_s) begin
      up_cnt <= 32'h0;
    end else if (up_cnt < RESET_HOLD_CYCLES) begin
      up_cnt <= up_cnt + 32'h1;
    end
  end

  assign access_ok = ok_s && (up_cnt >= RECOVERY_CYCLES);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      supply_reset_output <= 1'b0;
      supply_reset_oe     <= 1'b1;
    end else begin
      supply_reset_output <= 1'b0;
      supply_reset_oe     <= !ok_s || (up_cnt < RESET_HOLD_CYCLES);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host cycle decode; accesses take effect when the cycle ends
  logic       act_wr, act_rd, wr_prev, rd_prev, wr_end, rd_end, wd_access, flags_read;
  logic [3:0] cyc_addr;
  logic [7:0] cyc_data;

  assign act_wr = access_ok && !cs_n_s && ms_n_s && !we_n_s;
  assign act_rd = access_ok && !cs_n_s && ms_n_s && we_n_s && !oe_n_s;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_prev  <= 1'b0;
      rd_prev  <= 1'b0;
      cyc_addr <= 4'h0;
      cyc_data <= 8'h00;
    end else begin
      wr_prev <= act_wr;
      rd_prev <= act_rd;
      if (act_wr || act_rd) begin
        cyc_addr <= addr_s;
        cyc_data <= din_s;
      end
    end
  end

  // A cycle cut short by supply loss is dropped, never committed
  assign wr_end     = wr_prev && !act_wr && access_ok;
  assign rd_end     = rd_prev && !act_rd && access_ok;
  assign wd_access  = (wr_end || rd_end) && cyc_addr == rwps_pkg::REG_WATCHDOG;
  assign flags_read = rd_end && cyc_addr == rwps_pkg::REG_FLAGS;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] wdog;
  logic [1:0] alarm_en;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wdog     <= rwps_pkg::WATCHDOG_RESET;
      alarm_en <= rwps_pkg::ALARM_RESET;
    end else if (wr_end) begin
      if (cyc_addr == rwps_pkg::REG_WATCHDOG) begin
        wdog <= cyc_data;
      end
      if (cyc_addr == rwps_pkg::REG_ALARM) begin
        alarm_en <= cyc_data[rwps_pkg::ALARM_IRQ_EN_BIT -: 2];
      end
    end
  end

  logic [4:0] mult;
  logic [1:0] res;
  logic       steer, enabled;

  assign steer   = wdog[rwps_pkg::WD_STEER_BIT];
  assign mult    = wdog[rwps_pkg::WD_MULT_LSB +: rwps_pkg::WD_MULT_W];
  assign res     = wdog[rwps_pkg::WD_RES_W-1:0];
  // A zero multiplier gives a zero period, treated as off
  assign enabled = (wdog != 8'h00) && (mult != 5'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Timer on oscillator ticks
  // Four-second steps need a 17-bit prescaler
  function automatic logic [16:0] step_ticks(input logic [1:0] r);
    case (r)
      rwps_pkg::RES_SIXTEENTH: step_ticks = 17'(rwps_pkg::STEP_BASE_TICKS);
      rwps_pkg::RES_QUARTER:   step_ticks = 17'(rwps_pkg::STEP_BASE_TICKS * 4);
      rwps_pkg::RES_ONE:       step_ticks = 17'(rwps_pkg::STEP_BASE_TICKS * 16);
      default:                 step_ticks = 17'(rwps_pkg::STEP_BASE_TICKS * 64);
    endcase
  endfunction

  logic        osc_prev, osc_tick, step, timeout;
  logic [16:0] pre;
  logic [4:0]  steps;

  assign osc_tick = osc_s && !osc_prev && !halt_s;
  assign step     = osc_tick && (pre == step_ticks(res) - 17'h1);
  assign timeout  = enabled && step && (steps + 5'h1 == mult);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      osc_prev <= 1'b0;
      pre      <= 17'h0;
      steps    <= 5'h0;
    end else begin
      osc_prev <= osc_s;
      if (wd_access || !enabled || timeout) begin
        pre   <= 17'h0;
        steps <= 5'h0;
      end else if (step) begin
        pre   <= 17'h0;
        steps <= steps + 5'h1;
      end else if (osc_tick) begin
        pre <= pre + 17'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag, interrupt and read data
  logic timeout_flag, irq_pend;

  // A new timeout wins over a clear in the same cycle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      timeout_flag <= 1'b0;
      irq_pend     <= 1'b0;
    end else begin
      if (timeout) begin
        timeout_flag <= 1'b1;
      end else if (flags_read) begin
        timeout_flag <= 1'b0;
      end
      if (timeout && !steer) begin
        irq_pend <= 1'b1;
      end else if (flags_read || wd_access) begin
        irq_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      interrupt_output <= 1'b0;
      interrupt_oe     <= 1'b0;
    end else begin
      interrupt_output <= 1'b0;
      interrupt_oe     <= irq_pend;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      data_oe <= act_rd;
      case (addr_s)
        rwps_pkg::REG_FLAGS:    data_out <= {timeout_flag, 7'h00};
        rwps_pkg::REG_ALARM:    data_out <= {alarm_en, 6'h00};
        rwps_pkg::REG_WATCHDOG: data_out <= wdog;
        default:                data_out <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_timeout_steered;
    timeout && !steer;
  endsequence

  property p_irq_raise;
    @(posedge clock) disable iff (!rstn) s_timeout_steered |=> irq_pend ##1 interrupt_oe;
  endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("irq not raised");

  property p_irq_hold;
    @(posedge clock) disable iff (!rstn)
      irq_pend && !flags_read && !wd_access |=> irq_pend;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped early");

  property p_flag_set;
    @(posedge clock) disable iff (!rstn) timeout |=> timeout_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_disabled;
    @(posedge clock) disable iff (!rstn) wdog == 8'h00 |-> !timeout && steps == 5'h0;
  endproperty
  a_disabled: assert property (p_disabled) else $error("timer runs while off");

  property p_restart;
    @(posedge clock) disable iff (!rstn) wd_access |=> steps == 5'h0 && pre == 17'h0;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart");

  property p_float;
    @(posedge clock) disable iff (!rstn) !ok_s |=> !data_oe;
  endproperty
  a_float: assert property (p_float) else $error("data driven at low supply");

  property p_protect;
    @(posedge clock) disable iff (!rstn) !access_ok |=> $stable(wdog);
  endproperty
  a_protect: assert property (p_protect) else $error("write while protected");

  property p_rst_low;
    @(posedge clock) disable iff (!rstn) !ok_s |=> supply_reset_oe [*2];
  endproperty
  a_rst_low: assert property (p_rst_low) else $error("reset released");

  property p_osc_halt;
    @(posedge clock) disable iff (!rstn) halt_s && !wd_access && enabled |=> $stable(pre);
  endproperty
  a_osc_halt: assert property (p_osc_halt) else $error("count while halted");

endmodule
`default_nettype wire

// ---- test_rtc_watchdog_power_supervisor.sv ----
// Self-checking testbench of the watchdog supervisor
`timescale 1ns/10ps
`default_nettype none
module test_rtc_watchdog_power_supervisor;
  localparam int REC     = 20;
  localparam int HOLD    = 50;
  localparam int OSC_CYC = 4;
  logic       clock, rstn, supply, halt, ok;
  logic       cs_n, ms_n, we_n, oe_n, osc, data_oe;
  logic       int_out, int_oe, rst_out, rst_oe, irq_n, rst_pin_n;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, data_out;
  int         error_cnt = 0;
  int         checks_done = 0;
  int         cyc = 0;
  int         n;
  // Open-drain pins with pull-ups
  assign irq_n     = int_oe ? int_out : 1'b1;
  assign rst_pin_n = rst_oe ? rst_out : 1'b1;
  rwps_watchdog #(.RECOVERY_CYCLES(REC), .RESET_HOLD_CYCLES(HOLD)) DUT (
    .clock(clock), .rstn(rstn), .clock_select_n(cs_n), .memory_select_n(ms_n),
    .write_n(we_n), .output_n(oe_n), .addr(addr), .data_in(wdata),
    .supply_above_trip(supply), .osc_in(osc), .oscillator_halt_bit(halt),
    .data_out(data_out), .data_oe(data_oe), .interrupt_output(int_out),
    .interrupt_oe(int_oe), .supply_reset_output(rst_out), .supply_reset_oe(rst_oe));
  rwps_host host (
    .clock(clock), .data_oe(data_oe), .data_out(data_out), .cs_n(cs_n), .ms_n(ms_n),
    .we_n(we_n), .oe_n(oe_n), .addr(addr), .wdata(wdata), .osc(osc));
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Ceiling well above the longest planned sequence
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      error_cnt++;
      $display("BAD %0t run did not finish", $time);
      close_out();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Waits for the interrupt and judges the elapsed time against the period
  task automatic tmo(input int mult, input int res);
    int exp;
    exp = mult * (rwps_pkg::STEP_BASE_TICKS << (2 * res)) * OSC_CYC;
    n = 0;
    while (irq_n !== 1'b0 && n < exp + 64) begin
      @(posedge clock) #1;
      n++;
    end
    chk(8'(n > exp - 40 && n < exp + 40), 8'h01, "timeout period");
  endtask
  initial begin
    rstn   = 1'b0;
    supply = 1'b0;
    halt   = 1'b0;
    repeat (4) @(posedge clock);
    #1 rstn = 1'b1;
    chk({7'h0, rst_pin_n}, 8'h00, "reset pin at power-up");
    supply = 1'b1;
    host.wr(rwps_pkg::REG_WATCHDOG, 8'h14);
    chk({7'h0, rst_pin_n}, 8'h00, "reset pin during hold");
    repeat (HOLD) @(posedge clock);
    #1 chk({7'h0, rst_pin_n}, 8'h01, "reset pin after hold");
    host.rd(rwps_pkg::REG_WATCHDOG, rdata, ok);
    chk(rdata, 8'h00, "watchdog after power-up");
    host.rd(rwps_pkg::REG_ALARM, rdata, ok);
    chk(rdata & 8'hc0, 8'h00, "alarm enables after power-up");
    host.wr(rwps_pkg::REG_ALARM, 8'hc0);
    host.rd(rwps_pkg::REG_ALARM, rdata, ok);
    chk(rdata & 8'hc0, 8'hc0, "alarm enables written");
    host.wr(rwps_pkg::REG_WATCHDOG, 8'h04);
    host.rd(rwps_pkg::REG_WATCHDOG, rdata, ok);
    chk(rdata, 8'h04, "watchdog read back");
    tmo(1, 0);
    host.rd(rwps_pkg::REG_FLAGS, rdata, ok);
    chk(rdata & 8'h80, 8'h80, "timeout flag set");
    chk({7'h0, irq_n}, 8'h01, "interrupt cleared by flag read");
    host.rd(rwps_pkg::REG_FLAGS, rdata, ok);
    chk(rdata & 8'h80, 8'h00, "timeout flag cleared");
    host.wr(rwps_pkg::REG_WATCHDOG, 8'h00);
    repeat (9000) @(posedge clock);
    chk({7'h0, irq_n}, 8'h01, "disabled watchdog quiet");
    host.rd(rwps_pkg::REG_FLAGS, rdata, ok);
    chk(rdata & 8'h80, 8'h00, "no flag when disabled");
    host.wr(rwps_pkg::REG_WATCHDOG, 8'h08);
    repeat (6000) @(posedge clock);
    host.rd(rwps_pkg::REG_WATCHDOG, rdata, ok);
    chk(rdata, 8'h08, "watchdog before restart");
    tmo(2, 0);
    host.rd(rwps_pkg::REG_WATCHDOG, rdata, ok);
    chk({7'h0, irq_n}, 8'h01, "interrupt cleared by register access");
    chk(rdata, 8'h08, "watchdog after timeout");
    host.wr(rwps_pkg::REG_WATCHDOG, 8'h05);
    halt = 1'b1;
    repeat (1000) @(posedge clock);
    #1 halt = 1'b0;
    tmo(1, 1);
    host.rd(rwps_pkg::REG_FLAGS, rdata, ok);
    #1 supply = 1'b0;
    repeat (4) @(posedge clock);
    #1 chk({7'h0, rst_pin_n}, 8'h00, "reset pin on supply drop");
    host.rd(rwps_pkg::REG_WATCHDOG, rdata, ok);
    chk({7'h0, ok}, 8'h00, "data bus floats on low supply");
    host.wr(rwps_pkg::REG_WATCHDOG, 8'h14);
    supply = 1'b1;
    repeat (HOLD + 10) @(posedge clock);
    host.rd(rwps_pkg::REG_WATCHDOG, rdata, ok);
    chk(rdata, 8'h05, "write blocked on low supply");
    close_out();
  end
endmodule
`default_nettype wire
